/* File: logic/sxdfr_pkg.sv */
// constants and types for the sequencer exit detectors and fault recorder
package sxdfr_pkg;
  localparam int CLK_MHZ = 20;
  // times in ns, as specified; cycle counts derived from the clock rate
  localparam int FETCH_NS = 20000;
  localparam int FETCH_CYC = (FETCH_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_TICK_NS = 10000;
  localparam int SEQ_TICK_CYC = (SEQ_TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TO_TICK_NS = 100000;
  localparam int TO_TICK_CYC = (TO_TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_BYTE_NS = 250000;
  localparam int REC_BYTE_CYC = (REC_BYTE_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_DELAY_MAX_MS = 400;
  localparam int TO_DELAY_MAX_MS = 400;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FAULT = 12'h008;
  localparam logic [11:0] ADDR_LIVE_UVOV = 12'h00C;
  localparam logic [11:0] ADDR_LIVE_GL = 12'h010;
  localparam logic [11:0] ADDR_SNAP = 12'h014;
  localparam logic [11:0] ADDR_SNAP_INFO = 12'h018;
  localparam logic [11:0] DEF_BASE = 12'h400;
  localparam logic [11:0] DEF_MASK = 12'hC00;
  localparam logic [11:0] REC_BASE = 12'h800;
  localparam logic [11:0] REC_MASK = 12'hE00;
  localparam int DEF_ST_LSB = 4;
  localparam int DEF_WD_LSB = 2;
  localparam int REC_IX_LSB = 2;
  localparam logic [1:0] DEF_WORDS = 2'h3;

  // field positions
  localparam int CTRL_GOTO_BIT = 0;
  localparam int CTRL_TGT_LSB = 8;
  localparam int CTRL_RESCAN_BIT = 16;
  localparam int CTRL_ERASE_BIT = 17;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_FULL_BIT = 9;
  localparam int STAT_SLOT_LSB = 16;
  localparam int STAT_SCAN_BIT = 24;
  localparam int STAT_RUN_BIT = 25;
  localparam int HI_BYTE_LSB = 8;
  localparam int INFO_CAUSE_LSB = 8;

  // nonvolatile record region
  localparam logic [15:0] NV_REC_FIRST = 16'hF980;
  localparam logic [15:0] NV_REC_LAST = 16'hF9FF;
  localparam logic [15:0] NV_REC_LAST_SLOT = 16'hF9F8;
  localparam int REC_MEM_BYTES = 128;
  localparam logic [4:0] NUM_SLOTS = 5'h10;
  localparam logic [2:0] REC_LAST_BYTE = 3'h7;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int USED_FLAG_BIT = 7;

  localparam int NUM_STATES = 63;
  localparam logic [5:0] LAST_STATE = 6'h3E;
  localparam logic [5:0] FIRST_STATE = 6'h00;
  localparam int NUM_IN = 13;
  localparam logic [3:0] IN_WARN = 4'hC;

  typedef enum logic [1:0] {CAUSE_SEQ, CAUSE_TIMEOUT, CAUSE_MONITOR, CAUSE_GOTO} sxdfr_cause_t;

  typedef struct packed {
    logic [7:0] uv;
    logic [7:0] ov;
    logic [3:0] gpi;
    logic [7:0] lim;
  } sxdfr_live_t;

  // one state definition, three 32-bit words, word 0 in the low bits
  typedef struct packed {
    logic [3:0] pad2;
    logic record_en;
    logic latch_en;
    logic [12:0] mon_expect;
    logic [12:0] mon_mask;
    logic [7:0] prog_level;
    logic [5:0] mon_next;
    logic [5:0] to_next;
    logic [11:0] to_delay;
    logic [4:0] pad0;
    logic [15:0] seq_delay;
    logic seq_pol;
    logic [3:0] seq_sel;
    logic [5:0] seq_next;
  } sxdfr_def_t;
endpackage : sxdfr_pkg

/* File: logic/sxdfr_top.sv */
// state exit detectors, fault latch, status capture and fault record writer
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// - sequence exit on selected input reaching condition
// - sequence delay 10 us steps up to 400 ms
// - delay needs steady input; change restarts timer
// - monitor exit on any enabled input mismatch
// - monitor exit with no added delay
// - each state change waits 20 us fetch
// - timeout exit, 100 us steps up to 400 ms
// - outputs take state level, held in state
// - sticky fault bit per input, host readable
// - fault latching only in enabled states
// - live status unlatched, straight from inputs
// - compact status captured at every state change
// - records in 0xF980..0xF9FF, sixteen at most
// - marked state entry writes one record; an entry made while a record is being written or a scan runs writes none
// - record: flag, state, cause, status, checksum
// - eight bytes, about 250 us each
// - finish current record before another starts
// - power-on scan for first unused slot
// - program only; stop when all slots used
// - ORed warning selectable by all detectors; here only the sequence and monitor detectors take it, as input 12
// - host go-to forces unconditional advance
// - up to 63 states, any reachable
module sxdfr_top import sxdfr_pkg::*; #(
  parameter int REC_BYTE_CYC_P = REC_BYTE_CYC
) (
  input wire logic clk_in, // 20 MHz clock
  input wire logic rst_n_in, // async power-on reset
  input wire logic [7:0] sfd_fault_in, // supply fault detector fault flags
  input wire sxdfr_live_t live_in, // uv, ov, gpi levels, limit warnings
  input wire logic aux_warn_in, // secondary monitor warning
  input wire logic [11:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  output logic [7:0] prog_level_out, // programmable output levels
  output logic [5:0] cur_state_out, // current state number
  output logic rec_busy_out // record write in progress
);
  typedef enum {ENG_FETCH, ENG_RUN} sxdfr_eng_t;
  typedef enum {REC_SCAN, REC_IDLE, REC_WRITE} sxdfr_rec_t;
  logic [31:0] def_mem [64][3];
  logic [7:0] rec_mem [REC_MEM_BYTES];
  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, read data from a flop
  logic served, next_served;
  logic [31:0] rd_q, next_rd_q, rd_val, wmask, wd;
  logic acc_wr, is_def, is_rec, def_ok, goto_set, rescan_req, erase_req, prog_we;
  logic [5:0] def_st, goto_val, exit_tgt;
  logic [1:0] def_wd;
  logic [6:0] rec_ix, prog_ix;
  sxdfr_eng_t eng_st, next_eng_st;
  sxdfr_rec_t rec_st, next_rec_st;
  logic [5:0] cur_state, next_cur_state, prev_state, next_prev_state, goto_tgt, next_goto_tgt;
  logic [7:0] fault, next_fault, prog_q, next_prog_q, fault_clr, csum;
  sxdfr_live_t snap, next_snap;
  sxdfr_cause_t cause, next_cause;
  logic [4:0] slot, next_slot;
  logic goto_pend, next_goto_pend;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~served;
  assign avs_readdata_out = rd_q;
  assign is_def = (avs_address_in & DEF_MASK) == DEF_BASE;
  assign is_rec = (avs_address_in & REC_MASK) == REC_BASE;
  assign def_st = avs_address_in[DEF_ST_LSB +: 6];
  assign def_wd = avs_address_in[DEF_WD_LSB +: 2];
  assign def_ok = is_def && (def_st <= LAST_STATE) && (def_wd != DEF_WORDS);
  assign rec_ix = avs_address_in[REC_IX_LSB +: 7];
  assign acc_wr = avs_write_in & served;
  assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wd = avs_writedata_in & wmask;
  assign goto_set = acc_wr && avs_address_in == ADDR_CTRL && wd[CTRL_GOTO_BIT];
  assign goto_val = wd[CTRL_TGT_LSB +: 6];
  assign rescan_req = acc_wr && avs_address_in == ADDR_CTRL && wd[CTRL_RESCAN_BIT];
  assign erase_req = acc_wr && avs_address_in == ADDR_CTRL && wd[CTRL_ERASE_BIT];
  assign fault_clr = (acc_wr && avs_address_in == ADDR_FAULT) ? wd[7:0] : 8'h00;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (def_ok) begin
      rd_val = def_mem[def_st][def_wd];
    end else if (is_rec) begin
      rd_val = {24'h00_0000, rec_mem[rec_ix]};
    end else begin
      unique case (avs_address_in)
        ADDR_CTRL: rd_val[CTRL_TGT_LSB +: 6] = goto_tgt;
        ADDR_STATUS: begin
          rd_val[5:0] = cur_state;
          rd_val[STAT_BUSY_BIT] = rec_st == REC_WRITE;
          rd_val[STAT_FULL_BIT] = slot == NUM_SLOTS;
          rd_val[STAT_SLOT_LSB +: 5] = slot;
          rd_val[STAT_SCAN_BIT] = rec_st == REC_SCAN;
          rd_val[STAT_RUN_BIT] = eng_st == ENG_RUN;
        end
        ADDR_FAULT: rd_val[7:0] = fault;
        ADDR_LIVE_UVOV: rd_val[15:0] = {live_in.ov, live_in.uv};
        ADDR_LIVE_GL: rd_val[11:0] = {live_in.lim, live_in.gpi};
        ADDR_SNAP: rd_val[27:0] = snap;
        ADDR_SNAP_INFO: rd_val[9:0] = {cause, 2'h0, prev_state};
        default: rd_val = 32'h0000_0000;
      endcase
    end
    next_served = (avs_read_in | avs_write_in) & ~served;
    next_rd_q = next_served ? (avs_read_in ? rd_val : 32'h0000_0000) : rd_q;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      served <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      served <= next_served;
      rd_q <= next_rd_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // state definition store, host written
  // 63 definitions, index 63 refused
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      def_mem <= '{default: 32'h0000_0000};
    end else if (acc_wr && def_ok) begin
      def_mem[def_st][def_wd] <= (def_mem[def_st][def_wd] & ~wmask) | wd;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // sequencing engine and exit detectors
  sxdfr_def_t cur_def, next_cur_def, def_rd;
  logic [8:0] fetch_cnt, next_fetch_cnt;
  logic [7:0] seq_pre, next_seq_pre;
  logic [15:0] seq_units, next_seq_units;
  logic [10:0] to_pre, next_to_pre;
  logic [11:0] to_units, next_to_units;
  logic [NUM_IN-1:0] eng_in;
  logic warn, seq_match, seq_exit, mon_exit, to_exit, rec_start;
  assign def_rd = {def_mem[cur_state][2], def_mem[cur_state][1], def_mem[cur_state][0]};
  assign warn = (|live_in.lim) | aux_warn_in;
  assign eng_in = {warn, live_in.gpi, ~sfd_fault_in};
  assign seq_match = (cur_def.seq_sel <= IN_WARN) &&
                     (eng_in[cur_def.seq_sel] == cur_def.seq_pol);
  // exit only after full steady delay
  assign seq_exit = seq_match && (seq_units >= cur_def.seq_delay);
  // unfiltered, acts in the same cycle
  assign mon_exit = |((eng_in ^ cur_def.mon_expect) & cur_def.mon_mask);
  assign to_exit = (cur_def.to_delay != 12'h000) && (to_units >= cur_def.to_delay);
  always_comb begin
    next_eng_st = eng_st;
    next_cur_state = cur_state;
    next_cur_def = cur_def;
    next_prog_q = prog_q;
    next_fetch_cnt = fetch_cnt;
    next_seq_pre = seq_pre;
    next_seq_units = seq_units;
    next_to_pre = to_pre;
    next_to_units = to_units;
    next_snap = snap;
    next_prev_state = prev_state;
    next_cause = cause;
    next_goto_pend = goto_pend;
    next_goto_tgt = goto_tgt;
    exit_tgt = cur_state;
    rec_start = 1'b0;
    unique case (eng_st)
      ENG_FETCH: begin
        next_fetch_cnt = fetch_cnt + 9'h001;
        if (fetch_cnt == 9'(FETCH_CYC - 1)) begin
          next_cur_def = def_rd;
          // output levels fixed for the state
          next_prog_q = def_rd.prog_level;
          next_seq_pre = 8'h00;
          next_seq_units = 16'h0000;
          next_to_pre = 11'h000;
          next_to_units = 12'h000;
          next_eng_st = ENG_RUN;
          rec_start = def_rd.record_en;
        end
      end
      ENG_RUN: begin
        if (!seq_match) begin
          next_seq_pre = 8'h00;
          next_seq_units = 16'h0000;
        end else if (seq_units < cur_def.seq_delay) begin
          next_seq_pre = (seq_pre == 8'(SEQ_TICK_CYC - 1)) ? 8'h00 : seq_pre + 8'h01;
          next_seq_units = seq_units + {15'h0000, seq_pre == 8'(SEQ_TICK_CYC - 1)};
        end
        // timeout counts in 100 us units
        if (to_units < cur_def.to_delay) begin
          next_to_pre = (to_pre == 11'(TO_TICK_CYC - 1)) ? 11'h000 : to_pre + 11'h001;
          next_to_units = to_units + {11'h000, to_pre == 11'(TO_TICK_CYC - 1)};
        end
        // monitor, then go-to, then sequence, then timeout
        if (mon_exit) begin
          next_cause = CAUSE_MONITOR;
          exit_tgt = cur_def.mon_next;
        end else if (goto_pend) begin
          next_cause = CAUSE_GOTO;
          exit_tgt = goto_tgt;
          next_goto_pend = 1'b0;
        end else if (seq_exit) begin
          next_cause = CAUSE_SEQ;
          exit_tgt = cur_def.seq_next;
        end else if (to_exit) begin
          next_cause = CAUSE_TIMEOUT;
          exit_tgt = cur_def.to_next;
        end
        if (mon_exit || goto_pend || seq_exit || to_exit) begin
          next_snap = live_in;
          next_prev_state = cur_state;
          // reserved index falls back to the first state
          next_cur_state = (exit_tgt > LAST_STATE) ? FIRST_STATE : exit_tgt;
          next_fetch_cnt = 9'h000;
          next_eng_st = ENG_FETCH;
        end
      end
    endcase
    if (goto_set) begin
      next_goto_pend = 1'b1;
      next_goto_tgt = goto_val;
    end
    next_fault = fault & ~fault_clr;
    if (eng_st == ENG_RUN && cur_def.latch_en) begin
      next_fault = next_fault | sfd_fault_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng_st <= ENG_FETCH;
      cur_state <= FIRST_STATE;
      cur_def <= '0;
      prog_q <= 8'h00;
      fetch_cnt <= 9'h000;
      seq_pre <= 8'h00;
      seq_units <= 16'h0000;
      to_pre <= 11'h000;
      to_units <= 12'h000;
      snap <= '0;
      prev_state <= FIRST_STATE;
      cause <= CAUSE_SEQ;
      goto_pend <= 1'b0;
      goto_tgt <= FIRST_STATE;
      fault <= 8'h00;
    end else begin
      eng_st <= next_eng_st;
      cur_state <= next_cur_state;
      cur_def <= next_cur_def;
      prog_q <= next_prog_q;
      fetch_cnt <= next_fetch_cnt;
      seq_pre <= next_seq_pre;
      seq_units <= next_seq_units;
      to_pre <= next_to_pre;
      to_units <= next_to_units;
      snap <= next_snap;
      prev_state <= next_prev_state;
      cause <= next_cause;
      goto_pend <= next_goto_pend;
      goto_tgt <= next_goto_tgt;
      fault <= next_fault;
    end
  end
  assign prog_level_out = prog_q;
  assign cur_state_out = cur_state;
  //////////////////////////////////////////////////////////////////////////////
  // fault record writer
  logic [2:0] byte_ix, next_byte_ix;
  logic [15:0] wcnt, next_wcnt;
  logic [63:0] rec_buf, next_rec_buf;
  always_comb begin
    next_rec_st = rec_st;
    next_slot = slot;
    next_byte_ix = byte_ix;
    next_wcnt = wcnt;
    next_rec_buf = rec_buf;
    prog_we = 1'b0;
    prog_ix = {slot[3:0], byte_ix};
    // flag 0, state, cause, status, checksum
    csum = 8'h00 - {2'h0, prev_state} - {cause, 2'h0, snap.gpi} - snap.uv - snap.ov
           - snap.lim - fault;
    unique case (rec_st)
      // first slot whose flag still reads 1
      REC_SCAN: begin
        if (slot == NUM_SLOTS || rec_mem[{slot[3:0], 3'h0}][USED_FLAG_BIT]) begin
          next_rec_st = REC_IDLE;
        end else begin
          next_slot = slot + 5'h01;
        end
      end
      REC_IDLE: begin
        if (rescan_req) begin
          next_slot = 5'h00;
          next_rec_st = REC_SCAN;
        end else if (rec_start && slot != NUM_SLOTS) begin
          next_rec_buf = {csum, 8'h00, fault, snap.lim, snap.ov, snap.uv,
                          cause, 2'h0, snap.gpi, 2'h0, prev_state};
          next_byte_ix = 3'h0;
          next_wcnt = 16'h0000;
          next_rec_st = REC_WRITE;
        end
      end
      REC_WRITE: begin
        next_wcnt = wcnt + 16'h0001;
        if (wcnt == 16'(REC_BYTE_CYC_P - 1)) begin
          next_wcnt = 16'h0000;
          prog_we = 1'b1;
          next_byte_ix = byte_ix + 3'h1;
          if (byte_ix == REC_LAST_BYTE) begin
            next_slot = slot + 5'h01;
            next_rec_st = REC_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_st <= REC_SCAN;
      slot <= 5'h00;
      byte_ix <= 3'h0;
      wcnt <= 16'h0000;
      rec_buf <= 64'h0000_0000_0000_0000;
    end else begin
      rec_st <= next_rec_st;
      slot <= next_slot;
      byte_ix <= next_byte_ix;
      wcnt <= next_wcnt;
      rec_buf <= next_rec_buf;
    end
  end
  // 128 bytes model the reserved region, slot n at base plus 8n
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_mem <= '{default: ERASED_BYTE};
    end else if (erase_req) begin
      rec_mem <= '{default: ERASED_BYTE};
    end else if (prog_we) begin
      rec_mem[prog_ix] <= rec_mem[prog_ix] & rec_buf[byte_ix*8 +: 8];
    end
  end
  assign rec_busy_out = rec_st == REC_WRITE;
endmodule : sxdfr_top

/* File: dv/sxdfr_chk_sva.sv */
// checker of bus handshake, state change timing and record write length
`timescale 1ns/1ps
module sxdfr_chk import sxdfr_pkg::*; #(
  parameter int REC_BYTE_CYC_P = REC_BYTE_CYC
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic avs_waitrequest_out, // stall
  input wire logic [7:0] prog_level_out, // output levels
  input wire logic [5:0] cur_state_out, // state number
  input wire logic rec_busy_out // record write running
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [10:0] st_cnt;
  logic [15:0] bz_cnt;
  wire logic req = avs_read_in | avs_write_in;
  ////////////////////////////////////////////////////////////////
  // saturating, so a long stay in one state never wraps into the window
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_cnt <= 11'h000;
      bz_cnt <= 16'h0000;
    end else begin
      st_cnt <= $changed(cur_state_out) ? 11'h001 : st_cnt + {10'h000, ~&st_cnt};
      bz_cnt <= rec_busy_out ? bz_cnt + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_wait_one; req && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
  property p_wait_low; req && !avs_waitrequest_out |=> avs_waitrequest_out == req; endproperty
  a_wait_low: assert property (p_wait_low) else $error("wait low too long");
  property p_wait_idle; !req |-> !avs_waitrequest_out; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("stall with no request");
  property p_state_range; cur_state_out <= LAST_STATE; endproperty
  a_state_range: assert property (p_state_range) else $error("state out of range");
  property p_state_gap; $changed(cur_state_out) |-> st_cnt >= 11'h18F; endproperty
  a_state_gap: assert property (p_state_gap) else $error("state change inside fetch");
  property p_level_fetch;
    $changed(prog_level_out) |-> st_cnt >= 11'h18E && st_cnt <= 11'h191;
  endproperty
  a_level_fetch: assert property (p_level_fetch) else $error("level not at fetch end");
  property p_busy_entry; $rose(rec_busy_out) |-> st_cnt >= 11'h18E && st_cnt <= 11'h192; endproperty
  a_busy_entry: assert property (p_busy_entry) else $error("record not at entry");
  property p_busy_len;
    $fell(rec_busy_out) |-> bz_cnt >= 7 * REC_BYTE_CYC_P && bz_cnt <= 8 * REC_BYTE_CYC_P + 2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("record length wrong");
endmodule : sxdfr_chk

bind sxdfr_top sxdfr_chk #(.REC_BYTE_CYC_P(REC_BYTE_CYC_P)) u_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .prog_level_out(prog_level_out),
  .cur_state_out(cur_state_out),
  .rec_busy_out(rec_busy_out)
);

/* File: dv/sxdfr_far_side.sv */
// far-side model: supply fault detectors and status sources
`timescale 1ns/1ps
module sxdfr_far_side import sxdfr_pkg::*; (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic [7:0] fault_req_in, // demanded rail faults
  input wire sxdfr_live_t live_req_in, // demanded status levels
  output logic [7:0] sfd_fault_out, // detector fault flags
  output sxdfr_live_t live_out // comparator and input levels
);
  logic [7:0] stage;
  logic [7:0] next_stage;
  logic [7:0] next_fault;
  sxdfr_live_t next_live;
  ////////////////////////////////////////////////////////////////
  // detectors settle two cycles late; rails read faulted while in reset
  always_comb begin
    next_stage = fault_req_in;
    next_fault = stage;
    next_live = live_req_in;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage <= 8'hFF;
      sfd_fault_out <= 8'hFF;
      live_out <= sxdfr_live_t'(28'h0000000);
    end else begin
      stage <= next_stage;
      sfd_fault_out <= next_fault;
      live_out <= next_live;
    end
  end
endmodule : sxdfr_far_side

/* File: dv/test_sxdfr_top.sv */
// testbench: exits, fault latch, status capture and record writer
`timescale 1ns/1ps
module test_sxdfr_top import sxdfr_pkg::*; ;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] fault_req = 8'hFF;
  sxdfr_live_t live_req = 28'hA53C900;
  logic [7:0] sfd_fault;
  sxdfr_live_t live;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] prog_level_out;
  logic [5:0] cur_state_out;
  logic rec_busy_out;
  logic [31:0] rd;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  sxdfr_top #(.REC_BYTE_CYC_P(8)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sfd_fault_in(sfd_fault), .live_in(live), .aux_warn_in(1'b0),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .prog_level_out(prog_level_out), .cur_state_out(cur_state_out),
    .rec_busy_out(rec_busy_out));
  sxdfr_far_side u_far (.clk_in(clk_in), .rst_n_in(rst_n_in), .fault_req_in(fault_req),
    .live_req_in(live_req), .sfd_fault_out(sfd_fault), .live_out(live));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // expected run is about 11500 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 32'h9C40) begin
      num_errors = num_errors + 1;
      $display("FAIL %0t run timed out", $time);
      complete_run;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // master holds the request until it sees waitrequest low at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_write_in <= w;
    avs_read_in <= ~w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask : rdc
  task automatic st_chk(input logic [31:0] exp, input string m);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h001F0300, exp, m);
  endtask : st_chk
  task automatic goto(input logic [5:0] s);
    wr(ADDR_CTRL, {18'h00000, s, 7'h00, 1'h1});
  endtask : goto
  task automatic defs(input logic [5:0] s, input logic [31:0] w0, w1, w2);
    wr(DEF_BASE + {2'h0, s, 4'h0}, w0);
    wr(DEF_BASE + {2'h0, s, 4'h4}, w1);
    wr(DEF_BASE + {2'h0, s, 4'h8}, w2);
  endtask : defs
  task automatic wait_lvl(input logic [7:0] lvl);
    int n;
    n = 0;
    while (prog_level_out !== lvl && n < 16'h1388) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_lvl
  task automatic wait_done;
    int n;
    n = 0;
    while (rec_busy_out !== 1'b1 && n < 8'h08) begin
      @(posedge clk_in);
      n++;
    end
    while (rec_busy_out !== 1'b0 && n < 16'h0400) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_done
  // checksum makes the eight bytes sum to zero
  task automatic check_rec(input int slot, input logic [7:0] b0, b1, b5);
    logic [7:0] e [8];
    logic [7:0] s;
    e = '{b0, b1, live_req.uv, live_req.ov, live_req.lim, b5, 8'h00, 8'h00};
    s = 8'h00;
    for (int i = 0; i < 7; i++) s = s + e[i];
    e[7] = 8'h00 - s;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, REC_BASE + 12'((slot * 8 + i) * 4), 32'h0);
      chk({24'h000000, rd[7:0]}, {24'h000000, e[i]}, "record byte");
    end
  endtask : check_rec
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    fault_req <= 8'h01;
    rdc(ADDR_FAULT, 32'h0, "fault at reset");
    rdc(12'h01C, 32'h0, "unmapped read");
    wr(12'h01C, 32'hFFFFFFFF);
    rdc(12'h01C, 32'h0, "unmapped write");
    rdc(DEF_BASE + 12'h00C, 32'h0, "def word three");
    rdc(REC_BASE, 32'h000000FF, "first slot blank");
    rdc(REC_BASE + 12'h1FC, 32'h000000FF, "last byte blank");
    rdc(ADDR_LIVE_UVOV, 32'h00003CA5, "live uv ov");
    rdc(ADDR_LIVE_GL, 32'h00000009, "live gpi lim");
    chk({24'h000000, prog_level_out}, 32'h0, "level after reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_seq;
    int t;
    st_chk(32'h0, "scan found slot zero");
    goto(6'h01);
    wait_lvl(8'h11);
    fault_req[0] <= 1'b0;
    repeat (8'hC8) @(posedge clk_in);
    fault_req[0] <= 1'b1;
    repeat (8'h0A) @(posedge clk_in);
    fault_req[0] <= 1'b0;
    t = cyc;
    wait_lvl(8'h22);
    chk(32'((cyc - t) inside {[32'h31E:32'h32A]}), 32'h1, "delay restart");
    rdc(ADDR_FAULT, 32'h1, "fault latched");
    $display("test sequence done");
  endtask : t_seq
  task automatic t_timeout;
    int a;
    a = cyc;
    fault_req[5] <= 1'b1;
    repeat (4) @(posedge clk_in);
    rdc(ADDR_FAULT, 32'h1, "latch disabled");
    fault_req[5] <= 1'b0;
    wait_lvl(8'h33);
    chk(32'((cyc - a) inside {[32'h95C:32'h96A]}), 32'h1, "timeout delay");
    wait_done;
    check_rec(0, 8'h01, 8'h09, 8'h01);
    check_rec(1, 8'h02, 8'h49, 8'h01);
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_monitor;
    int b;
    rdc(ADDR_SNAP, 32'h0A53C900, "snapshot");
    live_req.uv <= 8'h5A;
    repeat (4) @(posedge clk_in);
    rdc(ADDR_LIVE_UVOV, 32'h00003C5A, "live follows");
    rdc(ADDR_SNAP, 32'h0A53C900, "snapshot held");
    fault_req[1] <= 1'b1;
    b = cyc;
    while (cur_state_out === 6'h03 && cyc - b < 64) @(posedge clk_in);
    chk(32'(cyc - b < 6), 32'h1, "monitor reaction");
    chk({26'h0000000, cur_state_out}, 32'h4, "monitor wins");
    wait_lvl(8'h44);
    rdc(ADDR_SNAP_INFO, 32'h00000203, "exit cause");
    wait_done;
    check_rec(2, 8'h03, 8'h89, 8'h03);
    fault_req[1] <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(ADDR_FAULT, 32'h3);
    rdc(ADDR_FAULT, 32'h0, "fault cleared");
    $display("test monitor done");
  endtask : t_monitor
  task automatic t_full;
    st_chk(32'h00030000, "three slots used");
    for (int k = 0; k < 13; k++) begin
      goto(k[0] ? 6'h04 : 6'h05);
      wait_lvl(k[0] ? 8'h44 : 8'h55);
      wait_done;
    end
    check_rec(3, 8'h04, 8'hC9, 8'h00);
    st_chk(32'h00100200, "all slots used");
    goto(6'h04);
    wait_lvl(8'h44);
    repeat (8'h10) @(posedge clk_in);
    chk({31'h00000000, rec_busy_out}, 32'h0, "no write when full");
    wr(ADDR_CTRL, 32'h00010000);
    repeat (8'h20) @(posedge clk_in);
    st_chk(32'h00100200, "rescan without erase");
    wr(ADDR_CTRL, 32'h00020000);
    rdc(REC_BASE, 32'h000000FF, "erased");
    wr(ADDR_CTRL, 32'h00010000);
    repeat (8'h20) @(posedge clk_in);
    st_chk(32'h0, "rescan after erase");
    $display("test full done");
  endtask : t_full
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    defs(6'h01, 32'h00001402, 32'h11000000, 32'h04000000);
    defs(6'h02, 32'h00000340, 32'h22003001, 32'h08000000);
    defs(6'h03, 32'h00000045, 32'h33100000, 32'h0C004002);
    defs(6'h04, 32'h00000340, 32'h44000000, 32'h08000000);
    defs(6'h05, 32'h00000340, 32'h55000000, 32'h08000000);
    t_seq;
    // state two stays long enough for its record
    t_timeout;
    t_monitor;
    t_full;
    complete_run;
  end
endmodule : test_sxdfr_top
